/* core/dlf_consts.svh */
// Register offsets, field positions and size constants for the data link block
`ifndef DLF_CONSTS_SVH
`define DLF_CONSTS_SVH
`define DLF_A_WMARK1 8'h00
`define DLF_A_RCS1_0 8'h01
`define DLF_A_TCS1_0 8'h05
`define DLF_A_TSBS1 8'h09
`define DLF_A_RSBS1 8'h0a
`define DLF_A_MAP1 8'h0b
`define DLF_A_STAT1 8'h0c
`define DLF_A_MASK1 8'h0d
`define DLF_A_INFO1 8'h0e
`define DLF_A_TFBA1 8'h0f
`define DLF_A_RPBA1 8'h10
`define DLF_A_TFIFO1 8'h11
`define DLF_A_RFIFO1 8'h12
`define DLF_CTRL_STRIDE 8'h20
`define DLF_A_RXLINK 8'hc0
`define DLF_A_TXLINK 8'hc1
`define DLF_A_MATCHA 8'hc2
`define DLF_A_MATCHB 8'hc3
`define DLF_A_LSTAT 8'hc4
`define DLF_A_LMASK 8'hc5
`define DLF_A_LCTRL 8'hc6
`define DLF_TX_LOW_LEVEL_FLAG_HI 5
`define DLF_TX_LOW_LEVEL_FLAG_LO 3
`define DLF_RX_HIGH_LEVEL_FLAG_HI 2
`define DLF_RX_HIGH_LEVEL_FLAG_LO 0
`define DLF_ST_TX_LOW_LEVEL_FLAG 0
`define DLF_ST_RX_HIGH_LEVEL_FLAG 1
`define DLF_LS_MATCH 1
`define DLF_LS_TXEMPTY 2
`define DLF_LS_RXFULL 3
`define DLF_LC_DESTUFF 0
`define DLF_LC_STUFF 1
`define DLF_LC_FSSRC 2
`define DLF_LC_MFLOAD 3
`define DLF_WM_SCALE 4
`define DLF_FIFO_DEPTH 8'd128
`define DLF_MORE_BIT 7
`define DLF_ONES_RUN 3'd5
`define DLF_ONES_MAX 3'd7
`endif

/* core/dlf_pkg.sv */
// Types shared by the data link block
package dlf_pkg;
  typedef enum logic [2:0] {
    DLF_PS_BUSY = 3'h0,
    DLF_PS_OK = 3'h1,
    DLF_PS_CRC = 3'h2,
    DLF_PS_ABORT = 3'h3,
    DLF_PS_OVFL = 3'h4
  } dlf_pstat_e;
  typedef enum logic [1:0] {
    DLF_MAP_CHAN = 2'h0,
    DLF_MAP_FDL = 2'h1,
    DLF_MAP_SA = 2'h2
  } dlf_map_e;
endpackage

/* core/dlf_msg_ctrl.sv */
// One message controller: FIFOs, watermarks, byte counts, mapping
`timescale 1ns/1ps
`default_nettype none
`include "dlf_consts.svh"
module dlf_msg_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] wr_wmark,
  input wire logic wmark_we,
  input wire logic [7:0] wdata,
  input wire logic tf_we,
  input wire logic rf_re,
  input wire logic tx_slot_bit,
  input wire logic tx_bit_take,
  input wire logic rx_bit,
  input wire logic rx_bit_en,
  input wire logic [4:0] chan,
  input wire logic [2:0] bitpos,
  input wire logic fdl_slot,
  input wire logic sa_slot,
  input wire logic [1:0] map_mode,
  input wire logic [31:0] rx_chans,
  input wire logic [31:0] tx_chans,
  input wire logic [7:0] rx_bitsel,
  input wire logic [7:0] tx_bitsel,
  input wire logic rx_byte_done,
  input wire logic rx_pkt_end,
  input wire logic [2:0] rx_pkt_code,
  output logic [7:0] wmark_r,
  output logic tx_low_level_flag,
  output logic rx_high_level_flag,
  output logic [7:0] tx_space,
  output logic [7:0] rx_avail,
  output logic [2:0] pkt_code_r,
  output logic [7:0] rf_dout,
  output logic tx_out_bit,
  output logic rx_sel,
  output logic tx_sel
);
  logic [7:0] tmem [0:127];
  logic [7:0] rmem [0:127];
  logic [7:0] tcnt_r;
  logic [7:0] rcnt_r;
  logic [6:0] twp_r;
  logic [6:0] trp_r;
  logic [6:0] rwp_r;
  logic [6:0] rrp_r;
  logic [2:0] tbit_r;
  logic [7:0] rsh_r;
  logic [2:0] rbit_r;
  logic [7:0] seg_r;
  logic seg_end_r;
  logic tpop;
  logic rpush;

  function automatic logic slot_hit(input logic [1:0] m, input logic [31:0] c,
                                    input logic [7:0] b);
    unique case (m)
      dlf_pkg::DLF_MAP_FDL: slot_hit = fdl_slot;
      dlf_pkg::DLF_MAP_SA: slot_hit = sa_slot & b[bitpos];
      default: slot_hit = c[chan] & ~b[bitpos];
    endcase
  endfunction

  // Mapping to link, overhead bits or any channels
  // Process form, so slot inputs read inside the function wake it
  always_comb begin
    rx_sel = slot_hit(map_mode, rx_chans, rx_bitsel);
    tx_sel = slot_hit(map_mode, tx_chans, tx_bitsel);
  end
  assign tpop = tx_bit_take & tx_sel & (tcnt_r != 8'd0) & (tbit_r == 3'd7);
  assign rpush = rx_bit_en & rx_sel & (rbit_r == 3'd7) &
                 (rcnt_r != `DLF_FIFO_DEPTH);
  assign tx_out_bit = (tcnt_r != 8'd0) ? tmem[trp_r][tbit_r] : tx_slot_bit;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) wmark_r <= 8'h00;
    else if (wmark_we) wmark_r <= wr_wmark;
  end

  always_ff @(posedge core_clk) begin
    if (tf_we && tcnt_r != `DLF_FIFO_DEPTH) tmem[twp_r] <= wdata;
    if (rpush) rmem[rwp_r] <= {rx_bit, rsh_r[7:1]};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      twp_r <= 7'h00;
      trp_r <= 7'h00;
      tcnt_r <= 8'h00;
      tbit_r <= 3'h0;
    end else begin
      if (tf_we && tcnt_r != `DLF_FIFO_DEPTH) twp_r <= twp_r + 7'd1;
      if (tx_bit_take && tx_sel && tcnt_r != 8'd0) tbit_r <= tbit_r + 3'd1;
      if (tpop) trp_r <= trp_r + 7'd1;
      tcnt_r <= tcnt_r + {7'd0, tf_we && tcnt_r != `DLF_FIFO_DEPTH}
                - {7'd0, tpop};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rwp_r <= 7'h00;
      rrp_r <= 7'h00;
      rcnt_r <= 8'h00;
      rsh_r <= 8'h00;
      rbit_r <= 3'h0;
    end else begin
      if (rx_bit_en && rx_sel) begin
        rsh_r <= {rx_bit, rsh_r[7:1]};
        rbit_r <= rbit_r + 3'd1;
      end
      if (rpush) rwp_r <= rwp_r + 7'd1;
      if (rf_re && rcnt_r != 8'd0) rrp_r <= rrp_r + 7'd1;
      rcnt_r <= rcnt_r + {7'd0, rpush}
                - {7'd0, rf_re && rcnt_r != 8'd0};
    end
  end

  // Segment count up to packet end; overflow ends the segment too
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      seg_r <= 8'h00;
      seg_end_r <= 1'b0;
      pkt_code_r <= dlf_pkg::DLF_PS_BUSY;
    end else begin
      if (rx_pkt_end || (rx_byte_done && rcnt_r == `DLF_FIFO_DEPTH)) begin
        seg_end_r <= 1'b1;
        pkt_code_r <= rx_pkt_end ? rx_pkt_code : dlf_pkg::DLF_PS_OVFL;
      end else if (rf_re && seg_r == 8'd1 && seg_end_r) begin
        seg_end_r <= 1'b0;
      end
      if (rpush && !(rf_re && seg_r != 8'd0)) seg_r <= seg_r + 8'd1;
      else if (!rpush && rf_re && seg_r != 8'd0) seg_r <= seg_r - 8'd1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_low_level_flag <= 1'b0;
      rx_high_level_flag <= 1'b0;
      tx_space <= `DLF_FIFO_DEPTH;
      rx_avail <= 8'h00;
      rf_dout <= 8'h00;
    end else begin
      tx_low_level_flag <= tcnt_r < ({5'd0, wmark_r[`DLF_TX_LOW_LEVEL_FLAG_HI:`DLF_TX_LOW_LEVEL_FLAG_LO]}
              << `DLF_WM_SCALE);
      rx_high_level_flag <= rcnt_r > ({5'd0, wmark_r[`DLF_RX_HIGH_LEVEL_FLAG_HI:`DLF_RX_HIGH_LEVEL_FLAG_LO]}
              << `DLF_WM_SCALE);
      tx_space <= `DLF_FIFO_DEPTH - tcnt_r;
      rx_avail <= {~seg_end_r, seg_r[6:0]};
      if (rf_re) rf_dout <= rmem[rrp_r];
    end
  end
endmodule
`default_nettype wire

/* core/dlf_top.sv */
// Data link block: two message controllers and the legacy link byte path
//
// Overview of operation
// - Watermark register holds tx low mark in bits 5:3, rx high mark in 2:0.
// - Tx low flag is live while the tx FIFO level is under its mark.
// - Rx high flag is live while the rx FIFO level is above its mark.
// - Each watermark flag drives the low-active interrupt only when unmasked.
// - Controller maps to T1 link, E1 overhead bits, or any channel set.
// - In channel mode selected bit positions can be excluded.
// - Four rx channel selects cover eight channels each, 1-32.
// - Four tx channel selects cover eight channels each, 1-32.
// - Tx space register reports bytes still writable to tx FIFO.
// - Rx byte count low seven bits give readable bytes up to packet end.
// - Rx byte count top bit is one while packet not terminated.
// - Packet status: busy, ok, crc error, abort, overflow codes.
// - Link bits shift into 8-bit rx register; each fill sets status, irq.
// - Rx byte equal to either match byte sets match status, irq.
// - Destuffer deletes zero after exactly five ones, keeps after six or more.
// - Legacy tx byte goes out LSB first on the tx link bit only.
// - After 8 bits set tx empty and irq; unrefreshed byte is resent.
// - Stuffer inserts a zero after every five consecutive ones.
`timescale 1ns/1ps
`default_nettype none
`include "dlf_consts.svh"
module dlf_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic rx_bit_pin,
  input wire logic rx_link_en,
  input wire logic tx_link_take,
  input wire logic mf_boundary,
  input wire logic [4:0] chan,
  input wire logic [2:0] bitpos,
  input wire logic fdl_slot,
  input wire logic sa_slot,
  input wire logic [1:0] pkt_end,
  input wire logic [5:0] pkt_code,
  input wire logic [1:0] byte_done,
  input wire logic [1:0] ctrl_tx_bit,
  output logic [7:0] rdata,
  output logic tx_link_bit,
  output logic [1:0] ctrl_tx_out,
  output logic int_n
);
  logic [2:0] rx_sync_r;
  logic rx_bit;
  logic [7:0] rcs_r [0:1][0:3];
  logic [7:0] tcs_r [0:1][0:3];
  logic [7:0] rsbs_r [0:1];
  logic [7:0] tsbs_r [0:1];
  logic [1:0] map_r [0:1];
  logic [1:0] mask_r [0:1];
  logic [7:0] wm [0:1];
  logic [1:0] tx_low_level_flag;
  logic [1:0] rx_high_level_flag;
  logic [7:0] tspace [0:1];
  logic [7:0] ravail [0:1];
  logic [2:0] pcode [0:1];
  logic [7:0] rfd [0:1];
  logic [1:0] rsel;
  logic [1:0] tsel;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_byte_r;
  logic [2:0] rx_cnt_r;
  logic [2:0] rx_ones_r;
  logic [7:0] tx_byte_r;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_cnt_r;
  logic [2:0] tx_ones_r;
  logic tx_new_r;
  logic [7:0] match_a_r;
  logic [7:0] match_b_r;
  logic [3:0] lstat_r;
  logic [3:0] lmask_r;
  logic [3:0] lctrl_r;
  logic rx_drop;
  logic rx_shift;
  logic rx_fill;
  logic tx_ins0;
  logic tx_done;
  logic link_irq;
  logic ctrl_irq;
  logic [7:0] rd_nxt;

  // ***************************************************************
  // Input synchronising
  // ***************************************************************
  // Two later stages must agree before a pin change counts
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rx_sync_r <= 3'h0;
    else rx_sync_r <= {rx_sync_r[1:0], rx_bit_pin};
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rx_bit <= 1'b0;
    else if (rx_sync_r[2] == rx_sync_r[1]) rx_bit <= rx_sync_r[2];
  end

  function automatic logic is_ctrl(input logic [7:0] a, input logic [7:0] base,
                                   input int k);
    is_ctrl = (a == base + 8'(k) * `DLF_CTRL_STRIDE);
  endfunction

  // ***************************************************************
  // Message controllers
  // ***************************************************************
  for (genvar k = 0; k < 2; k++) begin : g_ctrl
    logic [31:0] rch;
    logic [31:0] tch;
    assign rch = {rcs_r[k][3], rcs_r[k][2], rcs_r[k][1], rcs_r[k][0]};
    assign tch = {tcs_r[k][3], tcs_r[k][2], tcs_r[k][1], tcs_r[k][0]};
    dlf_msg_ctrl u_ctrl (
      .core_clk(core_clk),
      .rstn(rstn),
      .wr_wmark(wdata),
      .wmark_we(wr_en && is_ctrl(addr, `DLF_A_WMARK1, k)),
      .wdata(wdata),
      .tf_we(wr_en && is_ctrl(addr, `DLF_A_TFIFO1, k)),
      .rf_re(rd_en && is_ctrl(addr, `DLF_A_RFIFO1, k)),
      .tx_slot_bit(ctrl_tx_bit[k]),
      .tx_bit_take(tx_link_take),
      .rx_bit(rx_bit),
      .rx_bit_en(rx_link_en),
      .chan(chan),
      .bitpos(bitpos),
      .fdl_slot(fdl_slot),
      .sa_slot(sa_slot),
      .map_mode(map_r[k]),
      .rx_chans(rch),
      .tx_chans(tch),
      .rx_bitsel(rsbs_r[k]),
      .tx_bitsel(tsbs_r[k]),
      .rx_byte_done(byte_done[k]),
      .rx_pkt_end(pkt_end[k]),
      .rx_pkt_code(pkt_code[3*k +: 3]),
      .wmark_r(wm[k]),
      .tx_low_level_flag(tx_low_level_flag[k]),
      .rx_high_level_flag(rx_high_level_flag[k]),
      .tx_space(tspace[k]),
      .rx_avail(ravail[k]),
      .pkt_code_r(pcode[k]),
      .rf_dout(rfd[k]),
      .tx_out_bit(),
      .rx_sel(rsel[k]),
      .tx_sel(tsel[k])
    );
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) ctrl_tx_out <= 2'b00;
    else ctrl_tx_out <= tsel & ctrl_tx_bit;
  end

  // ***************************************************************
  // Controller configuration registers
  // ***************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < 2; k++) begin
        for (int j = 0; j < 4; j++) begin
          rcs_r[k][j] <= 8'h00;
          tcs_r[k][j] <= 8'h00;
        end
        rsbs_r[k] <= 8'h00;
        tsbs_r[k] <= 8'h00;
        map_r[k] <= 2'h0;
        mask_r[k] <= 2'h0;
      end
    end else if (wr_en) begin
      for (int k = 0; k < 2; k++) begin
        for (int j = 0; j < 4; j++) begin
          if (is_ctrl(addr, `DLF_A_RCS1_0 + 8'(j), k))
            rcs_r[k][j] <= wdata;
          if (is_ctrl(addr, `DLF_A_TCS1_0 + 8'(j), k))
            tcs_r[k][j] <= wdata;
        end
        if (is_ctrl(addr, `DLF_A_RSBS1, k)) rsbs_r[k] <= wdata;
        if (is_ctrl(addr, `DLF_A_TSBS1, k)) tsbs_r[k] <= wdata;
        if (is_ctrl(addr, `DLF_A_MAP1, k)) map_r[k] <= wdata[1:0];
        if (is_ctrl(addr, `DLF_A_MASK1, k)) mask_r[k] <= wdata[1:0];
      end
    end
  end

  // ***************************************************************
  // Legacy receive path
  // ***************************************************************
  // Zero after exactly five ones is dropped; six or more keep it
  assign rx_drop = lctrl_r[`DLF_LC_DESTUFF] && !rx_bit &&
                   rx_ones_r == `DLF_ONES_RUN;
  assign rx_shift = rx_link_en && !rx_drop;
  assign rx_fill = rx_shift && rx_cnt_r == 3'd7;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_sh_r <= 8'h00;
      rx_byte_r <= 8'h00;
      rx_cnt_r <= 3'h0;
      rx_ones_r <= 3'h0;
    end else if (rx_link_en) begin
      if (!rx_bit) rx_ones_r <= 3'h0;
      else if (rx_ones_r != `DLF_ONES_MAX) rx_ones_r <= rx_ones_r + 3'd1;
      if (rx_shift) begin
        rx_sh_r <= {rx_bit, rx_sh_r[7:1]};
        rx_cnt_r <= rx_cnt_r + 3'd1;
      end
      // Unread byte is simply overwritten by the next fill
      if (rx_fill) rx_byte_r <= {rx_bit, rx_sh_r[7:1]};
    end
  end

  // ***************************************************************
  // Legacy transmit path
  // ***************************************************************
  // At or past five ones: a run already long when stuffing starts is cut
  assign tx_ins0 = lctrl_r[`DLF_LC_STUFF] &&
                   tx_ones_r >= `DLF_ONES_RUN;
  assign tx_done = tx_link_take && !tx_ins0 && tx_cnt_r == 3'd7;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_byte_r <= 8'h00;
      tx_new_r <= 1'b0;
    end else if (wr_en && addr == `DLF_A_TXLINK) begin
      tx_byte_r <= wdata;
      tx_new_r <= 1'b1;
    end else if (tx_done || (mf_boundary && lctrl_r[`DLF_LC_MFLOAD])) begin
      tx_new_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_sh_r <= 8'h00;
      tx_cnt_r <= 3'h0;
      tx_ones_r <= 3'h0;
      tx_link_bit <= 1'b0;
    end else if (tx_link_take) begin
      if (tx_ins0) begin
        tx_link_bit <= 1'b0;
        tx_ones_r <= 3'h0;
      end else begin
        tx_link_bit <= tx_sh_r[0];
        // Saturate, so a long run never wraps back under five
        if (!tx_sh_r[0]) tx_ones_r <= 3'h0;
        else if (tx_ones_r != `DLF_ONES_MAX) tx_ones_r <= tx_ones_r + 3'd1;
        tx_cnt_r <= tx_cnt_r + 3'd1;
        // Reload from the held byte, so an old byte repeats
        if (tx_cnt_r == 3'd7) tx_sh_r <= tx_byte_r;
        else tx_sh_r <= {1'b0, tx_sh_r[7:1]};
      end
    end
  end

  // ***************************************************************
  // Legacy status, match and control
  // ***************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      match_a_r <= 8'h00;
      match_b_r <= 8'h00;
      lmask_r <= 4'h0;
      lctrl_r <= 4'h0;
    end else if (wr_en) begin
      if (addr == `DLF_A_MATCHA) match_a_r <= wdata;
      if (addr == `DLF_A_MATCHB) match_b_r <= wdata;
      if (addr == `DLF_A_LMASK) lmask_r <= wdata[3:0];
      if (addr == `DLF_A_LCTRL) lctrl_r <= wdata[3:0];
    end
  end

  // Read clears; a new event in the same cycle wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) lstat_r <= 4'h0;
    else begin
      lstat_r <= (rd_en && addr == `DLF_A_LSTAT) ? 4'h0 : lstat_r;
      if (rx_link_en && rx_fill) begin
        lstat_r[`DLF_LS_RXFULL] <= 1'b1;
        if ({rx_bit, rx_sh_r[7:1]} == match_a_r ||
            {rx_bit, rx_sh_r[7:1]} == match_b_r)
          lstat_r[`DLF_LS_MATCH] <= 1'b1;
      end
      if (tx_done) lstat_r[`DLF_LS_TXEMPTY] <= 1'b1;
    end
  end

  assign link_irq = |(lstat_r & lmask_r);

  // Mask bits line up with the status bits they gate
  assign ctrl_irq = |({rx_high_level_flag[0], tx_low_level_flag[0]} & mask_r[0]) ||
                    |({rx_high_level_flag[1], tx_low_level_flag[1]} & mask_r[1]);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) int_n <= 1'b1;
    else int_n <= !(link_irq || ctrl_irq);
  end

  // ***************************************************************
  // Read mux
  // ***************************************************************
  always_comb begin
    rd_nxt = 8'h00;
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 4; j++) begin
        if (is_ctrl(addr, `DLF_A_RCS1_0 + 8'(j), k)) rd_nxt = rcs_r[k][j];
        if (is_ctrl(addr, `DLF_A_TCS1_0 + 8'(j), k)) rd_nxt = tcs_r[k][j];
      end
      if (is_ctrl(addr, `DLF_A_WMARK1, k)) rd_nxt = {2'b00, wm[k][5:0]};
      if (is_ctrl(addr, `DLF_A_RSBS1, k)) rd_nxt = rsbs_r[k];
      if (is_ctrl(addr, `DLF_A_TSBS1, k)) rd_nxt = tsbs_r[k];
      if (is_ctrl(addr, `DLF_A_MAP1, k)) rd_nxt = {6'd0, map_r[k]};
      if (is_ctrl(addr, `DLF_A_MASK1, k)) rd_nxt = {6'd0, mask_r[k]};
      if (is_ctrl(addr, `DLF_A_STAT1, k)) rd_nxt = {6'd0, rx_high_level_flag[k], tx_low_level_flag[k]};
      if (is_ctrl(addr, `DLF_A_INFO1, k)) rd_nxt = {5'd0, pcode[k]};
      if (is_ctrl(addr, `DLF_A_TFBA1, k)) rd_nxt = tspace[k];
      if (is_ctrl(addr, `DLF_A_RPBA1, k)) rd_nxt = ravail[k];
      if (is_ctrl(addr, `DLF_A_RFIFO1, k)) rd_nxt = rfd[k];
    end
    if (addr == `DLF_A_RXLINK) rd_nxt = rx_byte_r;
    if (addr == `DLF_A_TXLINK) rd_nxt = tx_byte_r;
    if (addr == `DLF_A_MATCHA) rd_nxt = match_a_r;
    if (addr == `DLF_A_MATCHB) rd_nxt = match_b_r;
    if (addr == `DLF_A_LSTAT) rd_nxt = {4'd0, lstat_r};
    if (addr == `DLF_A_LMASK) rd_nxt = {4'd0, lmask_r};
    if (addr == `DLF_A_LCTRL) rd_nxt = {3'd0, tx_new_r, lctrl_r[2:0]};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rdata <= 8'h00;
    else if (rd_en) rdata <= rd_nxt;
  end
endmodule
`default_nettype wire

/* tb/dlf_chk_asserts.sv */
// Port-level concurrent checks for the data link block
`timescale 1ns/1ps
`default_nettype none
module dlf_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic rx_link_en,
  input wire logic tx_link_take,
  input wire logic [7:0] rdata,
  input wire logic tx_link_bit,
  input wire logic int_n
);
  logic [2:0] mask_r;
  logic stuff_on_r;
  logic take_d_r;
  logic [3:0] run_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // Shadow of the three mask registers, zero means no irq source
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask_r <= 3'h0;
    end else if (wr_en && addr == 8'h0d) begin
      mask_r[0] <= |wdata;
    end else if (wr_en && addr == 8'h2d) begin
      mask_r[1] <= |wdata;
    end else if (wr_en && addr == 8'hc5) begin
      mask_r[2] <= |wdata;
    end
  end
  // Ones run on the tx link; restarted on control writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stuff_on_r <= 1'b0;
      take_d_r <= 1'b0;
      run_r <= 4'h0;
    end else begin
      take_d_r <= tx_link_take;
      if (wr_en && addr == 8'hc6) begin
        stuff_on_r <= wdata[1];
        run_r <= 4'h0;
      end else if (take_d_r) begin
        run_r <= tx_link_bit ? run_r + 4'h1 : 4'h0;
      end
    end
  end
  sequence quiet_s;
    !rx_link_en [*6];
  endsequence
  sequence stat_rd_s;
    rd_en && addr == 8'hc4 && !rx_link_en;
  endsequence
  property clear_p;
    quiet_s ##1 stat_rd_s ##1 !rx_link_en ##1 stat_rd_s
      |=> !rdata[3] && !rdata[1];
  endproperty
  unmapped_read_a: assert property (
    rd_en && addr == 8'hff |=> rdata == 8'h00)
    else $error("unmapped read returned data");
  rdata_hold_a: assert property (!rd_en |=> $stable(rdata))
    else $error("read data moved without a read");
  txbit_hold_a: assert property (
    !tx_link_take |=> $stable(tx_link_bit))
    else $error("tx link bit moved without a slot");
  irq_masked_a: assert property ((mask_r == 3'h0) [*2] |-> int_n)
    else $error("interrupt low with all masks clear");
  stuff_run_a: assert property (stuff_on_r |-> run_r <= 4'd5)
    else $error("six ones sent with stuffing on");
  tx_space_a: assert property (
    rd_en && (addr == 8'h0f || addr == 8'h2f) |=> rdata <= 8'h80)
    else $error("tx space above fifo depth");
  info_code_a: assert property (
    rd_en && (addr == 8'h0e || addr == 8'h2e) |=> rdata <= 8'h04)
    else $error("packet code outside its encodings");
  status_clear_a: assert property (clear_p)
    else $error("link status not cleared by read");
endmodule
`default_nettype wire

/* tb/dlf_link_model.sv */
// Framer-side model: rx link bits in, tx link slots out
`timescale 1ns/1ps
`default_nettype none
module dlf_link_model (
  input wire logic core_clk,
  input wire logic tx_link_bit,
  output logic rx_bit_pin,
  output logic rx_link_en,
  output logic tx_link_take
);
  initial begin
    rx_bit_pin = 1'b0;
    rx_link_en = 1'b0;
    tx_link_take = 1'b0;
  end
  // LSB first; pin held long enough for the input synchroniser
  task automatic send_bits(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk) #1;
      rx_link_en = 1'b0;
      rx_bit_pin = b[i];
      repeat (4) @(posedge core_clk);
      #1 rx_link_en = 1'b1;
    end
    @(posedge core_clk) #1;
    rx_link_en = 1'b0;
    // Idle line shows the inverse, never a stale bit
    rx_bit_pin = ~rx_bit_pin;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic take_bits(input int n, output logic [31:0] got);
    got = 32'h0;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk) #1;
      tx_link_take = 1'b1;
      @(posedge core_clk) #1;
      tx_link_take = 1'b0;
      got[i] = tx_link_bit;
    end
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the data link block
`timescale 1ns/1ps
`default_nettype none
`include "dlf_consts.svh"
module testbench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic mf_boundary = 1'b0;
  logic [4:0] chan = 5'h00;
  logic [2:0] bitpos = 3'h0;
  logic fdl_slot = 1'b0;
  logic sa_slot = 1'b0;
  logic [1:0] pkt_end = 2'h0;
  logic [5:0] pkt_code = 6'h00;
  logic [1:0] byte_done = 2'h0;
  logic [1:0] ctrl_tx_bit = 2'h0;
  wire logic rx_bit_pin, rx_link_en, tx_link_take, tx_link_bit, int_n;
  wire logic [7:0] rdata;
  wire logic [1:0] ctrl_tx_out;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] v, w, t, ma, mb;
  logic [31:0] got;
  dlf_top dlf_top_inst (.core_clk(core_clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rx_bit_pin(rx_bit_pin),
    .rx_link_en(rx_link_en), .tx_link_take(tx_link_take),
    .mf_boundary(mf_boundary), .chan(chan), .bitpos(bitpos),
    .fdl_slot(fdl_slot), .sa_slot(sa_slot), .pkt_end(pkt_end),
    .pkt_code(pkt_code), .byte_done(byte_done), .ctrl_tx_bit(ctrl_tx_bit),
    .rdata(rdata), .tx_link_bit(tx_link_bit), .ctrl_tx_out(ctrl_tx_out),
    .int_n(int_n));
  dlf_link_model dlf_link_model_inst (.core_clk(core_clk),
    .tx_link_bit(tx_link_bit), .rx_bit_pin(rx_bit_pin),
    .rx_link_en(rx_link_en), .tx_link_take(tx_link_take));
  always #5 core_clk = ~core_clk;
  // Slot position wanders; no channel is mapped so no FIFO drains
  always @(posedge core_clk) begin
    #1 {chan, bitpos, fdl_slot, sa_slot, ctrl_tx_bit} = 12'($urandom);
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge core_clk) #1;
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) #1;
    addr = a;
    rd_en = 1'b1;
    @(posedge core_clk) #1;
    rd_en = 1'b0;
    d = rdata;
  endtask
  function automatic logic [7:0] exp_space(input int n);
    return (n >= 128) ? 8'h00 : `DLF_FIFO_DEPTH - 8'(n);
  endfunction
  function automatic logic [31:0] max_run(input logic [31:0] b);
    logic [31:0] r;
    logic [31:0] m;
    r = 0;
    m = 0;
    for (int i = 0; i < 32; i++) begin
      r = b[i] ? r + 1 : 0;
      m = (r > m) ? r : m;
    end
    return m;
  endfunction
  task automatic rx_case(input logic [15:0] b, input int n,
                         input logic [7:0] e);
    logic [7:0] s;
    dlf_link_model_inst.send_bits(b, n);
    rd(`DLF_A_LSTAT, s);
    chk(s[3], 1'b1);
    chk(s[1], 1'(e == ma || e == mb));
    rd(`DLF_A_LSTAT, s);
    chk(s[3], 1'b0);
    rd(`DLF_A_RXLINK, s);
    chk(s, e);
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
  initial begin
    v = 8'($urandom(24));
    repeat (8) @(posedge core_clk);
    #1 rstn = 1'b1;
    w = {2'b00, 3'd1, 3'($urandom)};
    wr(`DLF_A_WMARK1, w);
    rd(`DLF_A_WMARK1, v);
    chk(v, w);
    wr(8'hff, 8'h5a);
    rd(8'hff, v);
    chk(v, 8'h00);
    rd(`DLF_A_STAT1, v);
    chk(v[1:0], 2'b01);
    wr(`DLF_A_MASK1, 8'h01);
    repeat (3) @(posedge core_clk);
    chk(int_n, 1'b0);
    // Level 15 still under the mark of 16, level 16 is not
    for (int i = 0; i < 132; i++) begin
      wr(`DLF_A_TFIFO1, 8'($urandom));
      if (i == 14 || i == 15) begin
        rd(`DLF_A_STAT1, v);
        chk(v[0], 1'(i + 1 < 16 * int'(w[5:3])));
        rd(`DLF_A_TFBA1, v);
        chk(v, exp_space(i + 1));
      end
    end
    chk(int_n, 1'b1);
    rd(`DLF_A_TFBA1, v);
    chk(v, exp_space(132));
    wr(`DLF_A_MASK1, 8'h00);
    for (int c = 0; c < 5; c++) begin
      @(posedge core_clk) #1;
      pkt_code = {3'(4 - c), 3'(c)};
      pkt_end = 2'b11;
      @(posedge core_clk) #1;
      pkt_end = 2'b00;
      rd(`DLF_A_INFO1, v);
      chk(v, 8'(c));
      rd(`DLF_A_INFO1 + `DLF_CTRL_STRIDE, v);
      chk(v, 8'(4 - c));
    end
    rd(`DLF_A_RPBA1, v);
    chk(v, 8'h00);
    wr(`DLF_A_LCTRL, 8'h00);
    v = 8'($urandom);
    ma = v ^ 8'h01;
    mb = v ^ 8'h80;
    wr(`DLF_A_MATCHA, ma);
    wr(`DLF_A_MATCHB, mb);
    rx_case({8'h00, v}, 8, v);
    rx_case({8'h00, ma}, 8, ma);
    rx_case({8'h00, mb}, 8, mb);
    rx_case(16'h0000, 8, 8'h00);
    wr(`DLF_A_LCTRL, 8'h01);
    rx_case(16'h009f, 9, 8'h5f);
    rx_case(16'h003f, 8, 8'h3f);
    t = 8'($urandom);
    wr(`DLF_A_TXLINK, t);
    dlf_link_model_inst.take_bits(16, got);
    chk(got[15:8], t);
    rd(`DLF_A_LSTAT, v);
    chk(v[2], 1'b1);
    dlf_link_model_inst.take_bits(8, got);
    chk(got[7:0], t);
    wr(`DLF_A_LCTRL, 8'h02);
    wr(`DLF_A_TXLINK, 8'hff);
    dlf_link_model_inst.take_bits(32, got);
    chk(max_run(got), 32'd5);
    wr(`DLF_A_LCTRL, 8'h08);
    wr(`DLF_A_TXLINK, 8'h1c);
    rd(`DLF_A_TXLINK, v);
    chk(v, 8'h1c);
    // Second controller on the link slot; first stays unmapped
    wr(`DLF_A_MAP1 + `DLF_CTRL_STRIDE, 8'h01);
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk) #2;
      t = {6'd0, fdl_slot & ctrl_tx_bit[1], 1'b0};
      @(posedge core_clk) #2;
      chk(ctrl_tx_out, t[1:0]);
    end
    wrap_up();
  end
endmodule
bind dlf_top dlf_chk dlf_chk_inst (.core_clk(core_clk), .rstn(rstn),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rx_link_en(rx_link_en), .tx_link_take(tx_link_take), .rdata(rdata),
  .tx_link_bit(tx_link_bit), .int_n(int_n));
`default_nettype wire
